// [inc/csc_pkg.sv]
package csc_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned SYS_PERIOD_NS      = 8;
  // slowest legal card clock is 1 MHz
  localparam int unsigned CARD_PERIOD_MAX_NS = 1000;
  // two missing card periods mean the clock was halted
  localparam int unsigned STOP_CYC =
    (2 * CARD_PERIOD_MAX_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int unsigned STOP_W   = $clog2(STOP_CYC + 1);
  // counts in card clock cycles
  localparam int unsigned QUIET_CYC = 1860;
  localparam int unsigned GUARD_CYC = 744;
  localparam int unsigned LCNT_W    = 11;

  // ************************************************************
  // status information coding
  // ************************************************************
  localparam int unsigned STAT_VCLASS_BYTE = 14;
  localparam int unsigned STAT_VCLASS_BIT  = 5;
  localparam int unsigned FCHAR_CLKSTOP_BIT = 0;

  // ************************************************************
  // file identifiers
  // ************************************************************
  localparam logic [7:0]  FT_MASTER  = 8'h3f;
  localparam logic [7:0]  FT_DED1    = 8'h7f;
  localparam logic [7:0]  FT_DED2    = 8'h5f;
  localparam logic [7:0]  FT_ELEM0   = 8'h2f;
  localparam logic [7:0]  FT_ELEM1   = 8'h6f;
  localparam logic [7:0]  FT_ELEM2   = 8'h4f;
  localparam logic [15:0] FID_UNUSED = 16'hffff;
  localparam logic [1:0]  LVL_MASTER = 2'h0;
  localparam logic [1:0]  LVL_DED1   = 2'h1;
  localparam logic [1:0]  LVL_DED2   = 2'h2;

  typedef enum logic [1:0]
  {
    CSC_IDLE = 2'b01,
    CSC_OPER = 2'b10
  } csc_sess_e;

  typedef struct packed
  {
    logic       ok;
    logic       is_dir;
    logic [1:0] plvl;
  } csc_ftype_s;

  // type byte to kind and level of the parent it must sit under
  function automatic csc_ftype_s csc_decode(input logic [7:0] tb);
    csc_ftype_s r;
    r = '0;
    case (tb)
      FT_MASTER: r = '{1'b1, 1'b1, LVL_MASTER};
      FT_DED1:   r = '{1'b1, 1'b1, LVL_MASTER};
      FT_DED2:   r = '{1'b1, 1'b1, LVL_DED1};
      FT_ELEM0:  r = '{1'b1, 1'b0, LVL_MASTER};
      FT_ELEM1:  r = '{1'b1, 1'b0, LVL_DED1};
      FT_ELEM2:  r = '{1'b1, 1'b0, LVL_DED2};
      default:   r = '0;
    endcase
    return r;
  endfunction : csc_decode

endpackage : csc_pkg

// [inc/csc_link_if.sv]
interface csc_link_if;
  logic resp_tgl;
  logic restart_tgl;
  logic quiet;
  logic guard_ok;
  logic beat;

  modport sys
  (
    output resp_tgl,
    output restart_tgl,
    input  quiet,
    input  guard_ok,
    input  beat
  );

  modport link
  (
    input  resp_tgl,
    input  restart_tgl,
    output quiet,
    output guard_ok,
    output beat
  );
endinterface : csc_link_if

// [src/csc_link_watch.sv]
module csc_link_watch
  import csc_pkg::*;
(
  // card clock domain
  input wire logic card_clk,
  input wire logic arst_n,
  // towards system domain
  csc_link_if.link lk
);

  // ************************************************************
  // reset release synchronised to the card clock
  // ************************************************************
  logic rst_s1_q;
  logic rst_s2_q;

  always_ff @(posedge card_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // ************************************************************
  // event crossing and cycle counting
  // ************************************************************
  logic [1:0]        rsp_s1_q, rsp_s2_q, rsp_s3_q;
  logic [1:0]        rsp_s3_d;
  logic [LCNT_W-1:0] cnt_q, cnt_d;
  logic              quiet_q, quiet_d;
  logic              guard_q, guard_d;
  logic              beat_q, beat_d;

  always_comb
  begin
    rsp_s3_d = rsp_s2_q;
    beat_d   = ~beat_q;
    cnt_d    = cnt_q;
    // RULE_15 count since response
    if (rsp_s2_q != rsp_s3_q)
      cnt_d = '0;
    else if (cnt_q != LCNT_W'(QUIET_CYC))
      cnt_d = cnt_q + LCNT_W'(1);
    quiet_d = (cnt_d >= LCNT_W'(QUIET_CYC));
    // RULE_16 guard after restart
    guard_d = (cnt_d >= LCNT_W'(GUARD_CYC));
  end

  always_ff @(posedge card_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      rsp_s1_q <= '0;
      rsp_s2_q <= '0;
      rsp_s3_q <= '0;
      cnt_q    <= '0;
      quiet_q  <= 1'b0;
      guard_q  <= 1'b0;
      beat_q   <= 1'b0;
    end
    else
    begin
      rsp_s1_q <= {lk.restart_tgl, lk.resp_tgl};
      rsp_s2_q <= rsp_s1_q;
      rsp_s3_q <= rsp_s3_d;
      cnt_q    <= cnt_d;
      quiet_q  <= quiet_d;
      guard_q  <= guard_d;
      beat_q   <= beat_d;
    end
  end

  assign lk.quiet    = quiet_q;
  assign lk.guard_ok = guard_q;
  assign lk.beat     = beat_q;

endmodule : csc_link_watch

// [src/csc_session.sv]
// Functional notes
// [RULE_01] protocol zero always supported
// [RULE_02] protocol one optional, by parameter
// [RULE_03] low-voltage card advertises clock halt allowed
// [RULE_04] voltage class in byte 14 bit 5
// [RULE_05] host reads voltage class first
// [RULE_06] dual host starts at higher supply
// [RULE_07] dual host switches before next command
// [RULE_08] low-only host activates at lower supply
// [RULE_09] low-only host rejects unsuitable card quickly
// [RULE_10] supply change only via deactivation
// [RULE_11] host supplies clock, none internal
// [RULE_12] works from 1 to 5 MHz
// [RULE_13] host clock 1 to 4 MHz low supply
// [RULE_14] operating versus idle, data retained
// [RULE_15] host waits 1860 cycles before halt
// [RULE_16] host waits 744 cycles after restart
// [RULE_17] halt only when characteristics allow
// [RULE_18] programming contact left unconnected
// [RULE_19] files addressed by two-byte identifier
// [RULE_20] first byte encodes file type
// [RULE_21] no clash with siblings or ancestors
// [RULE_22] headers kept, fixed at personalisation
// [RULE_23] host runs rejection deadline timer
module csc_session
  import csc_pkg::*;
#(
  parameter int unsigned N_FILES    = 16,
  parameter int unsigned HDR_W      = 32,
  parameter bit          LV_CAPABLE = 1'b1,
  parameter bit          T1_SUPPORT = 1'b0
)
(
  // system clock and reset
  input  wire logic                       clock,
  input  wire logic                       arst_n,
  // card clock from the host
  input  wire logic                       card_clk,
  // command engine
  input  wire logic                       cmd_start,
  input  wire logic                       cmd_done,
  input  wire logic                       xfer_busy,
  input  wire logic                       resp_char_done,
  // file creation
  input  wire logic                       personalise,
  input  wire logic                       fc_req,
  input  wire logic [15:0]                fc_id,
  input  wire logic [$clog2(N_FILES)-1:0] fc_parent,
  input  wire logic [HDR_W-1:0]           fc_hdr,
  output logic                            fc_ack,
  output logic                            fc_err,
  output logic [$clog2(N_FILES)-1:0]      fc_index,
  // header read for status and get-response
  input  wire logic                       hr_req,
  input  wire logic [$clog2(N_FILES)-1:0] hr_index,
  output logic                            hr_valid,
  output logic                            hr_err,
  output logic [15:0]                     hr_id,
  output logic [HDR_W-1:0]                hr_data,
  // capability and status
  output logic                            proto_t0,
  output logic                            proto_t1,
  output logic [7:0]                      stat_byte14,
  output logic [7:0]                      file_char,
  output logic                            operating,
  output logic                            clk_stopped,
  output logic                            halt_ok,
  output logic                            cmd_guard_ok
);

  localparam int unsigned IW = $clog2(N_FILES);
  localparam int unsigned CW = $clog2(N_FILES + 1);

  // ************************************************************
  // link domain
  // ************************************************************
  csc_link_if lk ();

  // RULE_11 card logic on host clock
  csc_link_watch u_watch
  (
    .card_clk (card_clk),
    .arst_n   (arst_n),
    .lk       (lk)
  );

  // RULE_18 programming contact has no port

  // ************************************************************
  // clock presence and crossings
  // ************************************************************
  logic              bt_s1_q, bt_s2_q, bt_s3_q;
  logic              qt_s1_q, qt_s2_q;
  logic              gd_s1_q, gd_s2_q;
  logic [STOP_W-1:0] stall_q, stall_d;
  logic              stop_q, stop_d;
  logic              rsp_tgl_q, rsp_tgl_d;
  logic              rst_tgl_q, rst_tgl_d;
  logic              pend_q, pend_d;

  // RULE_12 a 1 MHz clock never looks stopped
  always_comb
  begin
    stall_d   = stall_q;
    stop_d    = stop_q;
    rsp_tgl_d = rsp_tgl_q ^ resp_char_done;
    rst_tgl_d = rst_tgl_q;
    // link counts from before the halt are stale until it has rearmed
    pend_d    = pend_q && gd_s2_q;
    if (bt_s2_q != bt_s3_q)
    begin
      stall_d = '0;
      stop_d  = 1'b0;
      // RULE_16 restart rearms guard
      if (stop_q)
      begin
        rst_tgl_d = ~rst_tgl_q;
        pend_d    = 1'b1;
      end
    end
    else if (stall_q != STOP_W'(STOP_CYC))
      stall_d = stall_q + STOP_W'(1);
    else
      stop_d = 1'b1;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bt_s1_q   <= 1'b0;
      bt_s2_q   <= 1'b0;
      bt_s3_q   <= 1'b0;
      qt_s1_q   <= 1'b0;
      qt_s2_q   <= 1'b0;
      gd_s1_q   <= 1'b0;
      gd_s2_q   <= 1'b0;
      stall_q   <= '0;
      stop_q    <= 1'b1;
      rsp_tgl_q <= 1'b0;
      rst_tgl_q <= 1'b0;
      pend_q    <= 1'b0;
    end
    else
    begin
      bt_s1_q   <= lk.beat;
      bt_s2_q   <= bt_s1_q;
      bt_s3_q   <= bt_s2_q;
      qt_s1_q   <= lk.quiet;
      qt_s2_q   <= qt_s1_q;
      gd_s1_q   <= lk.guard_ok;
      gd_s2_q   <= gd_s1_q;
      stall_q   <= stall_d;
      stop_q    <= stop_d;
      rsp_tgl_q <= rsp_tgl_d;
      rst_tgl_q <= rst_tgl_d;
      pend_q    <= pend_d;
    end
  end

  assign lk.resp_tgl    = rsp_tgl_q;
  assign lk.restart_tgl = rst_tgl_q;

  // ************************************************************
  // session state
  // ************************************************************
  csc_sess_e sess_q, sess_d;
  logic      busy_q, busy_d;

  // RULE_14 operating while busy
  always_comb
  begin
    busy_d = busy_q;
    if (cmd_start)
      busy_d = 1'b1;
    else if (cmd_done)
      busy_d = 1'b0;
    unique case (sess_q)
      CSC_IDLE: sess_d = (busy_d || xfer_busy) ? CSC_OPER : CSC_IDLE;
      CSC_OPER: sess_d = (busy_d || xfer_busy) ? CSC_OPER : CSC_IDLE;
      default:  sess_d = CSC_IDLE;
    endcase
  end

  // ************************************************************
  // file table, kept while idle
  // ************************************************************
  logic [15:0]    id_q  [N_FILES];
  logic [IW-1:0]  par_q [N_FILES];
  logic [1:0]     lvl_q [N_FILES];
  logic           dir_q [N_FILES];
  logic [HDR_W-1:0] hdr_q [N_FILES];
  logic [CW-1:0]  cnt_q, cnt_d;
  csc_ftype_s     ft;
  logic [IW-1:0]  a1, a2, slot;
  logic           clash, place_ok, accept;

  // RULE_19 two-byte identifier check
  always_comb
  begin
    // RULE_20 type byte decode
    ft   = csc_decode(fc_id[15:8]);
    slot = cnt_q[IW-1:0];
    a1   = par_q[fc_parent];
    a2   = par_q[a1];
    // RULE_21 siblings share no identifier
    clash = 1'b0;
    for (int i = 0; i < N_FILES; i++)
    begin
      if ((CW'(i) < cnt_q) && (par_q[i] == fc_parent) && (i != 0)
          && (id_q[i] == fc_id))
        clash = 1'b1;
    end
    // RULE_21 ancestors at most three deep
    if ((id_q[fc_parent] == fc_id) || (id_q[a1] == fc_id)
        || (id_q[a2] == fc_id))
      clash = clash || (cnt_q != '0);
    if (fc_id[15:8] == FT_MASTER)
      place_ok = (cnt_q == '0);
    else
      place_ok = (cnt_q != '0) && (CW'(fc_parent) < cnt_q)
                 && dir_q[fc_parent] && (lvl_q[fc_parent] == ft.plvl);
    // RULE_22 creation only while personalising
    accept = personalise && ft.ok && place_ok && !clash
             && (fc_id != FID_UNUSED) && (cnt_q != CW'(N_FILES));
    cnt_d = cnt_q;
    if (fc_req && accept)
      cnt_d = cnt_q + CW'(1);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < N_FILES; i++)
      begin
        id_q[i]  <= FID_UNUSED;
        par_q[i] <= '0;
        lvl_q[i] <= LVL_MASTER;
        dir_q[i] <= 1'b0;
        hdr_q[i] <= '0;
      end
      cnt_q  <= '0;
      sess_q <= CSC_IDLE;
      busy_q <= 1'b0;
    end
    else
    begin
      if (fc_req && accept)
      begin
        id_q[slot]  <= fc_id;
        par_q[slot] <= (cnt_q == '0) ? slot : fc_parent;
        lvl_q[slot] <= ft.is_dir && (cnt_q != '0) ? ft.plvl + 2'h1 : ft.plvl;
        dir_q[slot] <= ft.is_dir;
        hdr_q[slot] <= fc_hdr;
      end
      cnt_q  <= cnt_d;
      sess_q <= sess_d;
      busy_q <= busy_d;
    end
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fc_ack       <= 1'b0;
      fc_err       <= 1'b0;
      fc_index     <= '0;
      hr_valid     <= 1'b0;
      hr_err       <= 1'b0;
      hr_id        <= '0;
      hr_data      <= '0;
      proto_t0     <= 1'b0;
      proto_t1     <= 1'b0;
      stat_byte14  <= '0;
      file_char    <= '0;
      operating    <= 1'b0;
      clk_stopped  <= 1'b1;
      halt_ok      <= 1'b0;
      cmd_guard_ok <= 1'b0;
    end
    else
    begin
      fc_ack   <= fc_req && accept;
      fc_err   <= fc_req && !accept;
      fc_index <= fc_req ? slot : fc_index;
      // RULE_22 header returned on request
      hr_valid <= hr_req && (CW'(hr_index) < cnt_q);
      hr_err   <= hr_req && !(CW'(hr_index) < cnt_q);
      hr_id    <= hr_req ? id_q[hr_index] : hr_id;
      hr_data  <= hr_req ? hdr_q[hr_index] : hr_data;
      // RULE_01 protocol zero
      proto_t0 <= 1'b1;
      // RULE_02 protocol one optional
      proto_t1 <= T1_SUPPORT;
      // RULE_04 voltage class bit
      stat_byte14 <= 8'(LV_CAPABLE) << STAT_VCLASS_BIT;
      // RULE_03 clock halt allowed
      file_char <= 8'(LV_CAPABLE) << FCHAR_CLKSTOP_BIT;
      // RULE_14 state shown
      operating   <= (sess_d == CSC_OPER);
      clk_stopped <= stop_q;
      // RULE_17 halt needs permission
      halt_ok      <= qt_s2_q && LV_CAPABLE && (sess_q == CSC_IDLE) && !pend_q;
      // RULE_16 shut until the link counter restarts
      cmd_guard_ok <= gd_s2_q && !stop_q && !pend_q;
    end
  end

endmodule : csc_session

// [dv/csc_host_clk.sv]
module csc_host_clk
(
  // control from the bench
  input  wire logic run,
  // clock to the card
  output logic      card_clk
);
  timeunit 1ns;
  timeprecision 100ps;

  // one fixed rate for either supply
  // a halted clock rests low so the card never sees a stray edge
  initial
  begin
    card_clk = 1'b0;
    #0.6;
    forever
    begin
      #7.5;
      card_clk = run ? ~card_clk : 1'b0;
    end
  end
endmodule : csc_host_clk

// [dv/csc_session_chk.sv]
module csc_session_chk
  import csc_pkg::*;
#(
  parameter bit LV_CAPABLE = 1'b1
)
(
  // clock and reset
  input wire logic       clock,
  input wire logic       arst_n,
  // requests
  input wire logic       cmd_start,
  input wire logic       cmd_done,
  input wire logic       xfer_busy,
  input wire logic       personalise,
  input wire logic       fc_req,
  input wire logic [15:0] fc_id,
  input wire logic       hr_req,
  // answers
  input wire logic       fc_ack,
  input wire logic       fc_err,
  input wire logic       hr_valid,
  input wire logic       hr_err,
  input wire logic       proto_t0,
  input wire logic [7:0] stat_byte14,
  input wire logic [7:0] file_char,
  input wire logic       operating,
  input wire logic       clk_stopped,
  input wire logic       cmd_guard_ok
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  // ********
  // checks
  // ********
  // $past guard skips the first edge, where flops still hold reset values
  a_t0_always: assert property ($past(arst_n) |-> proto_t0)
    else $error("protocol zero missing");
  a_vclass_bit: assert property ($past(arst_n) |-> stat_byte14 == {2'h0, LV_CAPABLE, 5'h00})
    else $error("voltage class byte wrong");
  a_clkstop_char: assert property ($past(arst_n) |-> file_char[FCHAR_CLKSTOP_BIT] == LV_CAPABLE)
    else $error("clock stop flag wrong");
  a_create_answer: assert property (fc_req |=> fc_ack != fc_err)
    else $error("create answer missing");
  a_closed_create: assert property (fc_req && !personalise |=> fc_err)
    else $error("create outside personalisation");
  a_unused_id: assert property (fc_req && fc_id == FID_UNUSED |=> fc_err)
    else $error("unused identifier accepted");
  a_oper_start: assert property (cmd_start |=> operating)
    else $error("not operating after start");
  a_idle_after: assert property (cmd_done && !cmd_start && !xfer_busy |=> !operating)
    else $error("not idle after done");
  a_hr_answer: assert property (hr_req |=> hr_valid != hr_err)
    else $error("header answer missing");
  a_restart_guard: assert property ($fell(clk_stopped) |-> !cmd_guard_ok)
    else $error("guard open at restart");

  c_create: cover property (fc_ack);
  c_stop: cover property ($rose(clk_stopped));
  c_refuse: cover property (hr_err);
endmodule : csc_session_chk

bind csc_session csc_session_chk #(.LV_CAPABLE(LV_CAPABLE)) i_chk (
  .clock(clock), .arst_n(arst_n), .cmd_start(cmd_start), .cmd_done(cmd_done),
  .xfer_busy(xfer_busy), .personalise(personalise), .fc_req(fc_req), .fc_id(fc_id),
  .hr_req(hr_req), .fc_ack(fc_ack), .fc_err(fc_err), .hr_valid(hr_valid),
  .hr_err(hr_err), .proto_t0(proto_t0), .stat_byte14(stat_byte14),
  .file_char(file_char), .operating(operating), .clk_stopped(clk_stopped),
  .cmd_guard_ok(cmd_guard_ok)
);

// [dv/testbench.sv]
module testbench
  import csc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ********
  // bench
  // ********
  logic        arst_n = 1'b0, card_run = 1'b1, cmd_start = 1'b0, cmd_done = 1'b0;
  logic        xfer_busy = 1'b0, resp_char_done = 1'b0, personalise = 1'b0;
  logic        fc_req = 1'b0, hr_req = 1'b0, clock, card_clk;
  logic        fc_ack, fc_err, hr_valid, hr_err, proto_t0, proto_t1;
  logic        operating, clk_stopped, halt_ok, cmd_guard_ok;
  logic [3:0]  fc_parent = 4'h0, hr_index = 4'h0, fc_index;
  logic [7:0]  stat_byte14, file_char;
  logic [15:0] fc_id = 16'h0000, hr_id;
  logic [31:0] fc_hdr = 32'h00000000, hr_data;
  int          errors, checked;

  csc_host_clk i_host (.run(card_run), .card_clk(card_clk));

  csc_session #(.N_FILES(16), .HDR_W(32), .LV_CAPABLE(1'b1), .T1_SUPPORT(1'b0)) i_dut (
    .clock(clock), .arst_n(arst_n), .card_clk(card_clk), .cmd_start(cmd_start),
    .cmd_done(cmd_done), .xfer_busy(xfer_busy), .resp_char_done(resp_char_done),
    .personalise(personalise), .fc_req(fc_req), .fc_id(fc_id), .fc_parent(fc_parent),
    .fc_hdr(fc_hdr), .fc_ack(fc_ack), .fc_err(fc_err), .fc_index(fc_index),
    .hr_req(hr_req), .hr_index(hr_index), .hr_valid(hr_valid), .hr_err(hr_err),
    .hr_id(hr_id), .hr_data(hr_data), .proto_t0(proto_t0), .proto_t1(proto_t1),
    .stat_byte14(stat_byte14), .file_char(file_char), .operating(operating),
    .clk_stopped(clk_stopped), .halt_ok(halt_ok), .cmd_guard_ok(cmd_guard_ok)
  );

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // whole run is about 43 us; far past that something hangs
  // deadline counts one error and ends the run
  initial
  begin
    #200000;
    errors++;
    test_done();
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // card edges, then settle past a system edge
  task automatic ck(input int n);
    repeat (n) @(posedge card_clk);
    @(posedge clock);
    #1;
  endtask : ck

  task automatic mk(input logic [15:0] id, input logic [3:0] par, input logic ok,
                    input logic [3:0] idx);
    @(posedge clock);
    fc_req    <= 1'b1;
    fc_id     <= id;
    fc_parent <= par;
    fc_hdr    <= {~id, id};
    @(posedge clock);
    fc_req <= 1'b0;
    #1;
    chk("fc_ack", ok, fc_ack);
    chk("fc_err", !ok, fc_err);
    if (ok)
      chk("fc_index", idx, fc_index);
  endtask : mk

  task automatic rd(input logic [3:0] idx, input logic ok, input logic [15:0] id);
    @(posedge clock);
    hr_req   <= 1'b1;
    hr_index <= idx;
    @(posedge clock);
    hr_req <= 1'b0;
    #1;
    chk("hr_valid", ok, hr_valid);
    chk("hr_err", !ok, hr_err);
    if (ok)
    begin
      chk("hr_id", id, hr_id);
      chk("hr_data", {~id, id}, hr_data);
    end
  endtask : rd

  task automatic t_caps();
    repeat (2) @(posedge clock);
    #1;
    chk("proto_t0", 1'b1, proto_t0);
    chk("proto_t1", 1'b0, proto_t1);
    chk("stat_byte14", 8'h20, stat_byte14);
    chk("clock stop flag", 8'h01, file_char);
    if (stat_byte14[STAT_VCLASS_BIT])
    begin
      @(posedge clock);
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      chk("class after switch", 8'h20, stat_byte14);
    end
  endtask : t_caps

  task automatic t_files();
    logic [15:0] ids [6] = '{16'h3f00, 16'h7f90, 16'h6f01, 16'h5f10, 16'h4f20, 16'h2f00};
    logic [3:0]  par [6] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h3, 4'h0};
    mk(16'h3f00, 4'h0, 1'b0, 4'h0);
    @(posedge clock);
    personalise <= 1'b1;
    for (int i = 0; i < 6; i++)
      mk(ids[i], par[i], 1'b1, 4'(i));
    mk(16'h7f90, 4'h0, 1'b0, 4'h0);
    mk(16'hffff, 4'h0, 1'b0, 4'h0);
    mk(16'h1f00, 4'h0, 1'b0, 4'h0);
    mk(16'h6f02, 4'h0, 1'b0, 4'h0);
    mk(16'h2f01, 4'h9, 1'b0, 4'h0);
    rd(4'h1, 1'b1, 16'h7f90);
    rd(4'h4, 1'b1, 16'h4f20);
    rd(4'hf, 1'b0, 16'h0000);
  endtask : t_files

  task automatic t_sess();
    @(posedge clock);
    cmd_start <= 1'b1;
    @(posedge clock);
    cmd_start <= 1'b0;
    xfer_busy <= 1'b1;
    #1;
    chk("operating", 1'b1, operating);
    @(posedge clock);
    cmd_done <= 1'b1;
    @(posedge clock);
    cmd_done <= 1'b0;
    #1;
    chk("operating in transfer", 1'b1, operating);
    @(posedge clock);
    xfer_busy <= 1'b0;
    @(posedge clock);
    #1;
    chk("idle", 1'b0, operating);
    @(posedge clock);
    cmd_start <= 1'b1;
    @(posedge clock);
    cmd_start <= 1'b0;
    cmd_done  <= 1'b1;
    @(posedge clock);
    cmd_done <= 1'b0;
    #1;
    chk("idle after short command", 1'b0, operating);
  endtask : t_sess

  task automatic t_halt();
    @(posedge clock);
    resp_char_done <= 1'b1;
    @(posedge clock);
    resp_char_done <= 1'b0;
    ck(1800);
    chk("halt_ok early", 1'b0, halt_ok);
    ck(80);
    chk("halt_ok", 1'b1, halt_ok);
    chk("cmd_guard_ok", 1'b1, cmd_guard_ok);
  endtask : t_halt

  task automatic t_stop();
    @(posedge clock);
    card_run <= 1'b0;
    repeat (300) @(posedge clock);
    #1;
    chk("clk_stopped", 1'b1, clk_stopped);
    chk("guard when stopped", 1'b0, cmd_guard_ok);
    @(posedge clock);
    card_run <= 1'b1;
    ck(700);
    chk("clk_stopped", 1'b0, clk_stopped);
    chk("guard early", 1'b0, cmd_guard_ok);
    ck(60);
    chk("guard after restart", 1'b1, cmd_guard_ok);
  endtask : t_stop

  task automatic test_done();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    t_caps();
    t_files();
    t_sess();
    t_halt();
    t_stop();
    test_done();
  end
endmodule : testbench
